// File: dv/refclk_ctrl_sva.sv
// refclk_ctrl_sva: port-level checks of the request pin and apb timing.
// assumes it is bound to refclk_ctrl and sees only its ports.
`timescale 1ns/1ns
module refclk_ctrl_sva (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // apb
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  // pins
  input  wire logic        request_polarity_strap_i,
  input  wire logic        combine_mode_strap_i,
  input  wire logic        ext_req_i,
  input  wire logic        clk_req_o,
  input  wire logic        nvram_valid_i,
  input  wire logic [31:0] eff_freq_hz_o
);
  import refclk_pkg::*;
  logic gpio_q, gpio_d, gval_q, gval_d, unmapped;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // pin mode mirrored from apb writes, since it is not visible at the ports
  always_comb begin
    gpio_d = gpio_q;
    gval_d = gval_q;
    if (psel_i && penable_i && pwrite_i && paddr_i == CTRL_OFF) begin
      gpio_d = pwdata_i[CTRL_PIN_GPIO_BIT];
      gval_d = pwdata_i[CTRL_GPIO_VAL_BIT];
    end
  end
  always_ff @(posedge clk_i) begin
    gpio_q <= rst_b_i ? gpio_d : 1'b0;
    gval_q <= rst_b_i ? gval_d : 1'b0;
  end
  assign unmapped = !(paddr_i inside {CTRL_OFF, STATUS_OFF, REF_FREQ_OFF, TRIM_OFF,
                                      SLEEP_LEN_OFF, EFF_FREQ_OFF, DETECT_OFF});
  a_ready_after_setup:
    assert property (psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  a_ready_one_cycle:
    assert property (pready_o |=> !pready_o) else $error("ready held too long");
  a_err_unmapped:
    assert property (pready_o |-> pslverr_o == unmapped) else $error("bad slave error");
  a_reset_awake_req:
    assert property ($rose(rst_b_i) && !combine_mode_strap_i && !gpio_q
      |-> clk_req_o == request_polarity_strap_i) else $error("request not awake");
  a_comb_or_high:
    assert property (!gpio_q && combine_mode_strap_i && request_polarity_strap_i && ext_req_i
      |-> clk_req_o) else $error("or combine low");
  a_comb_and_low:
    assert property (!gpio_q && combine_mode_strap_i && !request_polarity_strap_i && !ext_req_i
      |-> !clk_req_o) else $error("and combine high");
  a_gpio_pin_drive:
    assert property (gpio_q |-> clk_req_o == gval_q) else $error("pin not gpio");
  a_eff_default:
    assert property ($rose(rst_b_i) && !nvram_valid_i
      |-> ##[1:2] eff_freq_hz_o == 32'h0131_2D00) else $error("default ref wrong");
endmodule : refclk_ctrl_sva
bind refclk_ctrl refclk_ctrl_sva chk_u (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .request_polarity_strap_i,
  .combine_mode_strap_i, .ext_req_i, .clk_req_o, .nvram_valid_i, .eff_freq_hz_o);

// File: dv/refclk_ctrl_tb.sv
// refclk_ctrl_tb: self-checking bench for request pin, apb map, trim, detect, sleep.
// assumes a short low-power divider so sleep periods stay brief.
`timescale 1ns/1ns
module refclk_ctrl_tb;
  import refclk_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, pol, comb, want, meas_v, err, nv_v, ok_exp;
  logic        ext_req, low_power_oscillator, tcxo_on, clk_req, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, eff;
  logic [15:0] meas_khz, nv_khz;
  logic [9:0]  ref_dev, lpo_dev;
  int          bad_count, n_tests, tv, last_t, exp_ref, cyc;
  int dk[5] = '{19200, 19200, 19300, 13000, 38400};
  int dr[5] = '{10, 50, 0, 0, 49};
  int dl[5] = '{100, 0, 0, 250, 249};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  refclk_ctrl #(.LPO_DIV(4)) dut_u (.clk_i(clk), .rst_b_i(rst_b), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .request_polarity_strap_i(pol), .combine_mode_strap_i(comb), .ext_req_i(ext_req),
    .clk_req_o(clk_req), .low_power_oscillator_ext_i(low_power_oscillator), .nvram_valid_i(nv_v),
    .nvram_ref_khz_i(nv_khz), .nvram_trim_i(6'h20), .meas_valid_i(meas_v),
    .meas_ref_khz_i(meas_khz), .meas_ref_dev_ppm_i(ref_dev),
    .meas_lpo_dev_ppm_i(lpo_dev), .eff_freq_hz_o(eff));
  tcxo_side_model far_u (.clk_i(clk), .request_polarity_strap_i(pol), .sys_want_i(want),
    .clk_req_i(clk_req), .ext_req_o(ext_req), .lpo_o(low_power_oscillator), .tcxo_on_o(tcxo_on));
  function automatic int clamp(input int v);
    return v > 25 ? 25 : (v < -25 ? -25 : v);
  endfunction : clamp
  function automatic logic [31:0] eff_of(input int khz, input int t);
    return 32'(khz * 1000 + t * (khz / 500));
  endfunction : eff_of
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // every strap and request combination, checked in the cycle it is applied
  task automatic req_sweep(input logic awake);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      comb <= i[2];
      pol <= i[1];
      want <= i[0];
      @(negedge clk);
      chk({31'h0, tcxo_on}, {31'h0, (i[2] && i[0]) || awake});
    end
  endtask : req_sweep
  task automatic nap(input logic [31:0] ctl, input int ticks, input int per);
    int t0;
    int n;
    apb(1'b1, SLEEP_LEN_OFF, 32'(ticks));
    apb(1'b1, CTRL_OFF, ctl);
    t0 = cyc;
    req_sweep(1'b0);
    n = 0;
    do begin
      apb(1'b0, STATUS_OFF, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 400);
    chk({31'h0, (cyc - t0) inside {[ticks * per - per : ticks * per + 16]}}, 32'h1);
  endtask : nap
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    {psel, penable, pwrite, paddr, pwdata, comb, want, meas_v, nv_v} = '0;
    {meas_khz, nv_khz, ref_dev, lpo_dev, bad_count, n_tests, last_t} = '0;
    pol = 1'b1;
    rst_b = 1'b0;
    exp_ref = 20000;
    tv = $urandom(69);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, REF_FREQ_OFF, 32'h0);
    chk(rd, 32'h0000_4E20);
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    req_sweep(1'b1);
    // limits first, then random steps inside the six-bit field
    for (int i = 0; i < 6; i++) begin
      tv = (i == 0) ? 31 : (i == 1) ? -31 : int'($urandom_range(62)) - 31;
      last_t = clamp(tv);
      apb(1'b1, TRIM_OFF, 32'(tv));
      apb(1'b0, TRIM_OFF, 32'h0);
      chk(rd, 32'(last_t));
      apb(1'b0, EFF_FREQ_OFF, 32'h0);
      chk(rd, eff_of(exp_ref, last_t));
      chk(eff, eff_of(exp_ref, last_t));
    end
    apb(1'b1, CTRL_OFF, 32'h6);
    @(negedge clk);
    chk({31'h0, clk_req}, 32'h1);
    apb(1'b1, CTRL_OFF, 32'h2);
    @(negedge clk);
    chk({31'h0, clk_req}, 32'h0);
    apb(1'b1, CTRL_OFF, 32'h0);
    nap(32'h1, 64, 4);
    nap(32'h9, 8, 16);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, CTRL_OFF, 32'h10);
      meas_v <= 1'b1;
      meas_khz <= 16'(dk[i]);
      ref_dev <= 10'(dr[i]);
      lpo_dev <= 10'(dl[i]);
      @(posedge clk);
      meas_v <= 1'b0;
      apb(1'b0, STATUS_OFF, 32'h0);
      ok_exp = dr[i] < REF_DEV_MAX_PPM && dl[i] < LPO_DEV_MAX_PPM && i != 2;
      chk({30'h0, rd[2:1]}, ok_exp ? 32'h1 : 32'h2);
      if (ok_exp) exp_ref = dk[i];
      apb(1'b0, DETECT_OFF, 32'h0);
      chk(rd, 32'(dk[i]));
      apb(1'b0, EFF_FREQ_OFF, 32'h0);
      chk(rd, eff_of(exp_ref, last_t));
    end
    // second reset: stored setting with out-of-range trim, active-low strap
    @(posedge clk);
    rst_b <= 1'b0;
    nv_v <= 1'b1;
    nv_khz <= 16'(12000 + $urandom_range(40000));
    comb <= 1'b0;
    pol <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, STATUS_OFF, 32'h0);
    chk(rd, 32'h0000_0009);
    apb(1'b0, REF_FREQ_OFF, 32'h0);
    chk(rd, 32'(nv_khz));
    apb(1'b0, TRIM_OFF, 32'h0);
    chk(rd, 32'(-TRIM_MAX_STEPS));
    apb(1'b0, EFF_FREQ_OFF, 32'h0);
    chk(rd, eff_of(int'(nv_khz), -TRIM_MAX_STEPS));
    @(negedge clk);
    chk({31'h0, clk_req}, 32'h0);
    wrap_up();
  end
  initial begin
    #200000;
    $display("[FAIL] %0t watchdog expired", $time);
    bad_count++;
    wrap_up();
  end
endmodule : refclk_ctrl_tb

// File: dv/tcxo_side_model.sv
// tcxo_side_model: system request source, the oscillator it feeds, low-power clock.
// assumes the bench gives the clock and the level the system wants.
`timescale 1ns/1ns
module tcxo_side_model (
  // clock
  input  wire logic clk_i,
  // bench control
  input  wire logic request_polarity_strap_i,
  input  wire logic sys_want_i,
  // pins
  input  wire logic clk_req_i,
  output logic      ext_req_o,
  output logic      lpo_o,
  output logic      tcxo_on_o
);
  logic [3:0] div_q = 4'h0;
  // request in output polarity, always driven firmly
  assign ext_req_o = request_polarity_strap_i ? sys_want_i : !sys_want_i;
  assign tcxo_on_o = request_polarity_strap_i ? clk_req_i : !clk_req_i;
  always @(posedge clk_i) div_q <= div_q + 4'h1;
  assign lpo_o = div_q[3];
endmodule : tcxo_side_model

// File: logic/clk_req_pad.sv
// clk_req_pad: pad-ring gate that forms the reference clock request pin.
// assumes straps and the external request are driven firmly, never floating.
`timescale 1ns/1ns
module clk_req_pad (
  // straps
  input  wire logic request_polarity_strap_i,
  input  wire logic combine_mode_strap_i,
  // requests
  input  wire logic awake_i,
  input  wire logic ext_req_i,
  // pin reuse
  input  wire logic pin_gpio_mode_i,
  input  wire logic gpio_val_i,
  // pad
  output logic      clk_req_o
);

  logic req_own;

  // no clock or reset here, so the gate works with the core asleep or off
  always_comb begin
    req_own = request_polarity_strap_i ? awake_i : ~awake_i;
    if (pin_gpio_mode_i) begin
      clk_req_o = gpio_val_i;
    end else if (!combine_mode_strap_i) begin
      clk_req_o = req_own;
    end else if (request_polarity_strap_i) begin
      clk_req_o = ext_req_i | awake_i;
    end else begin
      clk_req_o = ext_req_i & ~awake_i;
    end
  end

endmodule : clk_req_pad

// File: logic/refclk_ctrl.sv
// refclk_ctrl: reference clock request, reference setting, trimming,
// auto-detect and low-power sleep timing, reached over apb.
// assumes one 100 MHz clock; straps and pins synchronous to it.
//
// Operation
// - the request is asserted while awake and deasserted while asleep.
// - polarity strap 0 gives an active-low request, 1 an active-high one.
// - without the combine strap only the internal need drives the request.
// - combine with polarity 1 drives external request OR awake.
// - combine with polarity 0 drives external request AND NOT awake.
// - the combining gate works while the core sleeps or is powered off.
// - the request pin may be reassigned to general-purpose use.
// - the reference defaults to 20 MHz when nothing else is set.
// - reference frequency is tuned in 2 ppm steps, 40 Hz each at the 20 MHz default.
// - auto-detect accepts a standard value only within 50 and 250 ppm.
// - initial reference tolerance is trimmed over +-50 ppm.
// - sleep is timed from a 32.768 kHz low-power clock, external or internal.
// - a stored nonvolatile reference value, loaded at reset, overrides the default.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module refclk_ctrl #(
  parameter int unsigned LPO_DIV = refclk_pkg::INT_LPO_DIV
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // straps and request pins
  input  wire logic        request_polarity_strap_i,
  input  wire logic        combine_mode_strap_i,
  input  wire logic        ext_req_i,
  output logic             clk_req_o,
  // low-power oscillator
  input  wire logic        low_power_oscillator_ext_i,
  // nonvolatile configuration
  input  wire logic        nvram_valid_i,
  input  wire logic [15:0] nvram_ref_khz_i,
  input  wire logic [5:0]  nvram_trim_i,
  // frequency measurement for auto-detect
  input  wire logic        meas_valid_i,
  input  wire logic [15:0] meas_ref_khz_i,
  input  wire logic [9:0]  meas_ref_dev_ppm_i,
  input  wire logic [9:0]  meas_lpo_dev_ppm_i,
  // synthesizer setting
  output logic [31:0]      eff_freq_hz_o
);
  import refclk_pkg::*;

  // standard handset reference values in kHz
  function automatic logic is_std_khz(input logic [15:0] khz);
    case (khz)
      16'd12000, 16'd13000, 16'd14400, 16'd15360, 16'd16200, 16'd16800,
      16'd18000, 16'd19200, 16'd19440, 16'd19680, 16'd19800, 16'd20000,
      16'd24000, 16'd26000, 16'd33600, 16'd37400, 16'd38400: is_std_khz = 1'b1;
      default: is_std_khz = 1'b0;
    endcase
  endfunction : is_std_khz

  // clamp a signed step count into the trim range
  function automatic logic [5:0] clamp_trim(input logic [5:0] raw);
    logic signed [6:0] v;
    v = 7'($signed(raw));
    if (v > 7'(TRIM_MAX_STEPS)) begin
      clamp_trim = 6'(TRIM_MAX_STEPS);
    end else if (v < -7'(TRIM_MAX_STEPS)) begin
      clamp_trim = 6'(-TRIM_MAX_STEPS);
    end else begin
      clamp_trim = raw;
    end
  endfunction : clamp_trim

  // state
  pwr_state_t  state_q,     state_d;
  logic [15:0] ref_khz_q,   ref_khz_d;
  logic [5:0]  trim_q,      trim_d;
  logic [15:0] sleep_len_q, sleep_len_d;
  logic [15:0] sleep_cnt_q, sleep_cnt_d;
  logic        pin_gpio_q,  pin_gpio_d;
  logic        gpio_val_q,  gpio_val_d;
  logic        lpo_ext_q,   lpo_ext_d;
  logic        det_busy_q,  det_busy_d;
  logic        det_ok_q,    det_ok_d;
  logic        det_fail_q,  det_fail_d;
  logic [15:0] det_khz_q,   det_khz_d;
  logic        nv_done_q,   nv_done_d;
  logic        nv_used_q,   nv_used_d;
  logic [11:0] div_cnt_q,   div_cnt_d;
  logic        lpo_ext_dl_q;
  logic        lpo_int_q,   lpo_int_d;
  logic [31:0] prdata_q,    prdata_d;
  logic        pready_q,    pready_d;
  logic        pslverr_q,   pslverr_d;
  logic [31:0] eff_q,       eff_d;

  logic        setup;
  logic        wr;
  logic        lpo_tick;
  logic        awake;
  logic signed [31:0] step_hz;

  assign setup = psel_i & ~penable_i;
  assign wr    = psel_i & penable_i & pwrite_i;
  assign awake = (state_q != ST_SLEEP);

  // low-power tick, external edge or internal divider
  assign lpo_tick = lpo_ext_q ? (low_power_oscillator_ext_i & ~lpo_ext_dl_q) : lpo_int_q;

  always_comb begin
    div_cnt_d = div_cnt_q + 12'h001;
    lpo_int_d = 1'b0;
    if (div_cnt_q == 12'(LPO_DIV - 1)) begin
      div_cnt_d = 12'h000;
      lpo_int_d = 1'b1;
    end
  end

  // power state and sleep timing
  always_comb begin
    state_d     = state_q;
    sleep_cnt_d = sleep_cnt_q;
    case (state_q)
      ST_AWAKE: begin
        if (wr && paddr_i == CTRL_OFF && pwdata_i[CTRL_SLEEP_BIT]) begin
          state_d     = ST_SLEEP;
          sleep_cnt_d = sleep_len_q;
        end
      end
      ST_SLEEP: begin
        if (lpo_tick) begin
          if (sleep_cnt_q <= 16'h0001) begin
            state_d = ST_WAKE;
          end
          sleep_cnt_d = sleep_cnt_q - 16'h0001;
        end
      end
      ST_WAKE: begin
        state_d     = ST_AWAKE;
        sleep_cnt_d = 16'h0000;
      end
      default: begin
        state_d = ST_AWAKE;
      end
    endcase
  end

  // configuration, nonvolatile load and auto-detect
  always_comb begin
    ref_khz_d   = ref_khz_q;
    trim_d      = trim_q;
    sleep_len_d = sleep_len_q;
    pin_gpio_d  = pin_gpio_q;
    gpio_val_d  = gpio_val_q;
    lpo_ext_d   = lpo_ext_q;
    det_busy_d  = det_busy_q;
    det_ok_d    = det_ok_q;
    det_fail_d  = det_fail_q;
    det_khz_d   = det_khz_q;
    nv_done_d   = 1'b1;
    nv_used_d   = nv_used_q;
    // stored value caught once after reset release
    if (!nv_done_q && nvram_valid_i) begin
      ref_khz_d = nvram_ref_khz_i;
      trim_d    = clamp_trim(nvram_trim_i);
      nv_used_d = 1'b1;
    end
    // detect only within both deviation limits
    if (det_busy_q && meas_valid_i) begin
      det_busy_d = 1'b0;
      det_khz_d  = meas_ref_khz_i;
      if (is_std_khz(meas_ref_khz_i) &&
          meas_ref_dev_ppm_i < 10'(REF_DEV_MAX_PPM) &&
          meas_lpo_dev_ppm_i < 10'(LPO_DEV_MAX_PPM)) begin
        ref_khz_d = meas_ref_khz_i;
        det_ok_d  = 1'b1;
      end else begin
        det_fail_d = 1'b1;
      end
    end
    if (wr) begin
      case (paddr_i)
        CTRL_OFF: begin
          pin_gpio_d = pwdata_i[CTRL_PIN_GPIO_BIT];
          gpio_val_d = pwdata_i[CTRL_GPIO_VAL_BIT];
          lpo_ext_d  = pwdata_i[CTRL_LPO_EXT_BIT];
          if (pwdata_i[CTRL_DETECT_BIT] && !(det_busy_q && meas_valid_i)) begin
            det_busy_d = 1'b1;
            det_ok_d   = 1'b0;
            det_fail_d = 1'b0;
          end
        end
        REF_FREQ_OFF:  ref_khz_d   = pwdata_i[15:0];
        TRIM_OFF:      trim_d      = clamp_trim(pwdata_i[5:0]);
        SLEEP_LEN_OFF: sleep_len_d = pwdata_i[15:0];
        default: begin
        end
      endcase
    end
  end

  // one step is 2 ppm of the reference
  always_comb begin
    step_hz = 32'($signed({16'h0000, ref_khz_q}) / KHZ_PER_STEP_DIV);
    eff_d   = 32'(32'(ref_khz_q) * 32'd1000 + 32'($signed(trim_q) * step_hz));
  end

  // apb: read data and answer prepared in setup, shown in access
  always_comb begin
    prdata_d  = prdata_q;
    pready_d  = setup;
    pslverr_d = 1'b0;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      case (paddr_i)
        CTRL_OFF: begin
          prdata_d[CTRL_PIN_GPIO_BIT] = pin_gpio_q;
          prdata_d[CTRL_GPIO_VAL_BIT] = gpio_val_q;
          prdata_d[CTRL_LPO_EXT_BIT]  = lpo_ext_q;
          prdata_d[CTRL_DETECT_BIT]   = det_busy_q;
        end
        STATUS_OFF: begin
          prdata_d[STAT_AWAKE_BIT]    = awake;
          prdata_d[STAT_DET_OK_BIT]   = det_ok_q;
          prdata_d[STAT_DET_FAIL_BIT] = det_fail_q;
          prdata_d[STAT_NVRAM_BIT]    = nv_used_q;
          prdata_d[STAT_POL_BIT]      = request_polarity_strap_i;
          prdata_d[STAT_COMBINE_BIT]  = combine_mode_strap_i;
        end
        REF_FREQ_OFF:  prdata_d[15:0] = ref_khz_q;
        TRIM_OFF:      prdata_d       = 32'($signed(trim_q));
        SLEEP_LEN_OFF: prdata_d[15:0] = sleep_len_q;
        EFF_FREQ_OFF:  prdata_d       = eff_q;
        DETECT_OFF:    prdata_d[15:0] = det_khz_q;
        default:       pslverr_d      = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q      <= ST_AWAKE;
      ref_khz_q    <= DEFAULT_REF_KHZ;
      trim_q       <= TRIM_RESET;
      sleep_len_q  <= SLEEP_LEN_RESET;
      sleep_cnt_q  <= 16'h0000;
      pin_gpio_q   <= 1'b0;
      gpio_val_q   <= 1'b0;
      lpo_ext_q    <= 1'b0;
      det_busy_q   <= 1'b0;
      det_ok_q     <= 1'b0;
      det_fail_q   <= 1'b0;
      det_khz_q    <= 16'h0000;
      nv_done_q    <= 1'b0;
      nv_used_q    <= 1'b0;
      div_cnt_q    <= 12'h000;
      lpo_ext_dl_q <= 1'b0;
      lpo_int_q    <= 1'b0;
      prdata_q     <= 32'h0000_0000;
      pready_q     <= 1'b0;
      pslverr_q    <= 1'b0;
      eff_q        <= 32'h0000_0000;
    end else begin
      state_q      <= state_d;
      ref_khz_q    <= ref_khz_d;
      trim_q       <= trim_d;
      sleep_len_q  <= sleep_len_d;
      sleep_cnt_q  <= sleep_cnt_d;
      pin_gpio_q   <= pin_gpio_d;
      gpio_val_q   <= gpio_val_d;
      lpo_ext_q    <= lpo_ext_d;
      det_busy_q   <= det_busy_d;
      det_ok_q     <= det_ok_d;
      det_fail_q   <= det_fail_d;
      det_khz_q    <= det_khz_d;
      nv_done_q    <= nv_done_d;
      nv_used_q    <= nv_used_d;
      div_cnt_q    <= div_cnt_d;
      lpo_ext_dl_q <= low_power_oscillator_ext_i;
      lpo_int_q    <= lpo_int_d;
      prdata_q     <= prdata_d;
      pready_q     <= pready_d;
      pslverr_q    <= pslverr_d;
      eff_q        <= eff_d;
    end
  end

  assign prdata_o      = prdata_q;
  assign pready_o      = pready_q;
  assign pslverr_o     = pslverr_q;
  assign eff_freq_hz_o = eff_q;

  // combinational request gate; the only output not from a flop
  clk_req_pad u_pad (
    .request_polarity_strap_i (request_polarity_strap_i),
    .combine_mode_strap_i     (combine_mode_strap_i),
    .awake_i                  (awake),
    .ext_req_i                (ext_req_i),
    .pin_gpio_mode_i          (pin_gpio_q),
    .gpio_val_i               (gpio_val_q),
    .clk_req_o                (clk_req_o)
  );

endmodule : refclk_ctrl

// File: logic/refclk_pkg.sv
// refclk_pkg: offsets, field positions, reset values and timing counts
// for the reference clock request block; assumes a 32-bit apb map.
package refclk_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF      = 8'h00;
  localparam logic [7:0] STATUS_OFF    = 8'h04;
  localparam logic [7:0] REF_FREQ_OFF  = 8'h08;
  localparam logic [7:0] TRIM_OFF      = 8'h0C;
  localparam logic [7:0] SLEEP_LEN_OFF = 8'h10;
  localparam logic [7:0] EFF_FREQ_OFF  = 8'h14;
  localparam logic [7:0] DETECT_OFF    = 8'h18;

  // control field positions
  localparam int CTRL_SLEEP_BIT    = 0;
  localparam int CTRL_PIN_GPIO_BIT = 1;
  localparam int CTRL_GPIO_VAL_BIT = 2;
  localparam int CTRL_LPO_EXT_BIT  = 3;
  localparam int CTRL_DETECT_BIT   = 4;

  // status field positions
  localparam int STAT_AWAKE_BIT    = 0;
  localparam int STAT_DET_OK_BIT   = 1;
  localparam int STAT_DET_FAIL_BIT = 2;
  localparam int STAT_NVRAM_BIT    = 3;
  localparam int STAT_POL_BIT      = 4;
  localparam int STAT_COMBINE_BIT  = 5;

  // reset values
  localparam logic [15:0] DEFAULT_REF_KHZ   = 16'h4E20;
  localparam logic [5:0]  TRIM_RESET        = 6'h00;
  localparam logic [15:0] SLEEP_LEN_RESET   = 16'h0020;

  // trimming: 2 ppm steps over +-50 ppm
  localparam int TRIM_STEP_PPM  = 2;
  localparam int TRIM_RANGE_PPM = 50;
  localparam int TRIM_MAX_STEPS = TRIM_RANGE_PPM / TRIM_STEP_PPM;
  localparam int KHZ_PER_STEP_DIV = 1000 / TRIM_STEP_PPM;

  // auto-detect limits in ppm
  localparam int REF_DEV_MAX_PPM = 50;
  localparam int LPO_DEV_MAX_PPM = 250;

  // timing
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int LPO_FREQ_HZ = 32_768;
  localparam int INT_LPO_DIV = CLK_FREQ_HZ / LPO_FREQ_HZ;

  // core power state, gray along awake -> sleep -> wake
  typedef enum logic [1:0] {
    ST_AWAKE = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b11
  } pwr_state_t;

endpackage : refclk_pkg
